// File: hw/hsc_pkg.sv
// constants and types of the homing sequence controller
// assumes one 20 MHz clock with a synchronous reset and an apb register port
// Function
// RQ1: home switch wired only to home_sensor_input
// RQ2: limit switches act only when enabled
// RQ3: torque limited to homing torque while homing
// RQ4: host sets input levels and mask first
// RQ5: codes -4/-3 torque homing positive/negative
// RQ6: codes -2/-1 torque homing then index, servo
// RQ7: reject unsupported codes, accept listed only
// RQ8: codes 3-6 home switch then index side
// RQ9: codes 7/11 reverse on home, stop index
// RQ10: codes 8/12 first index after home switch
// RQ11: codes 9/13 reverse on limit, then index
// RQ12: codes 10/14 reverse limit, reverse home, index
// RQ13: codes 20/22 home switch only, no index
// RQ14: codes 24-30 stop at home switch; only 24/26/28/30 are decoded, 25/27/29 are rejected
// RQ15: codes 33/34 move and stop at index
// RQ16: code 35 present position, 37 loads offset
// RQ17: host uses offset opposite homing direction
// RQ18: host uses clock sync for cyclic position
// RQ19: cyclic position discouraged without clock sync
// RQ20: no mode change until homing finished
// RQ21: completion flag, reference only on success
package hsc_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_METHOD = 8'h04;
    localparam logic [7:0] OFF_HTORQ = 8'h08;
    localparam logic [7:0] OFF_OFFSET = 8'h0C;
    localparam logic [7:0] OFF_PTORQ = 8'h10;
    localparam logic [7:0] OFF_MODE = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_REFPOS = 8'h1C;
    localparam int CTRL_START = 0;
    localparam int CTRL_LIMEN = 1;
    localparam int CTRL_SERVO = 2;
    localparam int CTRL_CLR = 3;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ERR = 2;
    localparam int ST_REF = 3;
    localparam int ST_REFUSED = 4;
    localparam logic [7:0] MODE_HOMING = 8'h06;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] METHOD_RST = 8'h00;
    localparam logic [15:0] TORQ_RST = 16'h0000;
    localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_POS = 32'h0000_0000;

    typedef enum logic [2:0]
    {
        K_TORQ = 3'h0,
        K_SWITCH = 3'h1,
        K_INDEX = 3'h2,
        K_HERE = 3'h3,
        K_OFFSET = 3'h4
    } hsc_kind_t;

    typedef struct packed
    {
        logic valid;
        hsc_kind_t kind;
        logic dir_pos;
        logic use_idx;
        logic flip_home;
        logic rev_lim;
        logic chk_home;
    } hsc_desc_t;

    typedef enum logic [2:0]
    {
        S_IDLE = 3'b000,
        S_SRCH = 3'b001,
        S_TORQ = 3'b011,
        S_INDX = 3'b010
    } hsc_state_t;
endpackage

// File: hw/hsc_regs_if.sv
// carrier between the apb register file and the homing core
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface hsc_regs_if;
    logic start_p;
    logic clr_p;
    logic mode_wr_p;
    logic [7:0] mode_wdata;
    logic [7:0] method;
    logic [15:0] htorq;
    logic [15:0] ptorq;
    logic [31:0] offset;
    logic lim_en;
    logic servo;
    logic [4:0] status;
    logic [7:0] mode_act;
    logic [31:0] ref_pos;
    modport regs
    (
        output start_p, clr_p, mode_wr_p, mode_wdata, method, htorq, ptorq,
        output offset, lim_en, servo,
        input status, mode_act, ref_pos
    );
    modport core
    (
        input start_p, clr_p, mode_wr_p, mode_wdata, method, htorq, ptorq,
        input offset, lim_en, servo,
        output status, mode_act, ref_pos
    );
endinterface

// File: hw/hsc_apb_regs.sv
// apb slave holding the software view of the homing controller
// assumes an apb master on the same clock; pready answers in the first access cycle
`timescale 1ns/1ps
module hsc_apb_regs
(
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    hsc_regs_if.regs rif
);
    import hsc_pkg::*;
    logic [31:0] prdata_reg;
    logic start_reg, clr_reg, mwr_reg, lim_reg, servo_reg;
    logic [7:0] mdata_reg, method_reg;
    logic [15:0] htorq_reg, ptorq_reg;
    logic [31:0] offset_reg;
    logic wr_ok;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= OFF_REFPOS);
    endfunction

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = prdata_reg;
    assign wr_ok = psel && penable && pwrite && mapped(paddr);

    // read data is fetched in the setup cycle so it stands in a flop during access
    always_ff @(posedge clk)
    begin
        if (srst)
            prdata_reg <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            case (paddr)
                OFF_CTRL: prdata_reg <= {29'h0, servo_reg, lim_reg, 1'b0};
                OFF_METHOD: prdata_reg <= {24'h00_0000, method_reg};
                OFF_HTORQ: prdata_reg <= {16'h0000, htorq_reg};
                OFF_OFFSET: prdata_reg <= offset_reg;
                OFF_PTORQ: prdata_reg <= {16'h0000, ptorq_reg};
                OFF_MODE: prdata_reg <= {24'h00_0000, rif.mode_act};
                OFF_STATUS: prdata_reg <= {27'h0, rif.status};
                OFF_REFPOS: prdata_reg <= rif.ref_pos;
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            start_reg <= 1'b0;
            clr_reg <= 1'b0;
            mwr_reg <= 1'b0;
            mdata_reg <= MODE_RST;
            lim_reg <= 1'b0;
            servo_reg <= 1'b0;
            method_reg <= METHOD_RST;
            htorq_reg <= TORQ_RST;
            ptorq_reg <= TORQ_RST;
            offset_reg <= OFFSET_RST;
        end
        else
        begin
            start_reg <= wr_ok && paddr == OFF_CTRL && pwdata[CTRL_START];
            clr_reg <= wr_ok && paddr == OFF_CTRL && pwdata[CTRL_CLR];
            mwr_reg <= wr_ok && paddr == OFF_MODE;
            if (wr_ok && paddr == OFF_MODE)
                mdata_reg <= pwdata[7:0];
            if (wr_ok && paddr == OFF_CTRL)
            begin
                lim_reg <= pwdata[CTRL_LIMEN]; // RQ2
                servo_reg <= pwdata[CTRL_SERVO];
            end
            if (wr_ok && paddr == OFF_METHOD)
                method_reg <= pwdata[7:0];
            if (wr_ok && paddr == OFF_HTORQ)
                htorq_reg <= pwdata[15:0];
            if (wr_ok && paddr == OFF_PTORQ)
                ptorq_reg <= pwdata[15:0];
            if (wr_ok && paddr == OFF_OFFSET)
                offset_reg <= pwdata;
        end
    end

    assign rif.start_p = start_reg;
    assign rif.clr_p = clr_reg;
    assign rif.mode_wr_p = mwr_reg;
    assign rif.mode_wdata = mdata_reg;
    assign rif.method = method_reg;
    assign rif.htorq = htorq_reg;
    assign rif.ptorq = ptorq_reg;
    assign rif.offset = offset_reg;
    assign rif.lim_en = lim_reg;
    assign rif.servo = servo_reg;
endmodule

// File: hw/hsc_method_dec.sv
// homing method decoder: signed code and drive variant to a search descriptor
// assumes the code is stable while a run is started
`timescale 1ns/1ps
module hsc_method_dec
(
    input wire logic [7:0] method,
    input wire logic servo,
    output hsc_pkg::hsc_desc_t desc
);
    import hsc_pkg::*;

    function automatic hsc_desc_t mk(input hsc_kind_t k, input logic d, input logic i,
        input logic f, input logic l, input logic c);
        mk = '{valid: 1'b1, kind: k, dir_pos: d, use_idx: i, flip_home: f,
            rev_lim: l, chk_home: c};
    endfunction

    // servo-only codes fall through to invalid on the other variant
    function automatic hsc_desc_t dec(input logic [7:0] m, input logic sv);
        hsc_desc_t so;
        hsc_desc_t r;
        so = '0;
        r = '0;
        case (m)
            8'hFE: so = mk(K_TORQ, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0); // RQ6
            8'hFF: so = mk(K_TORQ, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0); // RQ6
            8'h03: so = mk(K_SWITCH, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0); // RQ8
            8'h04: so = mk(K_SWITCH, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0); // RQ8
            8'h05: so = mk(K_SWITCH, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0); // RQ8
            8'h06: so = mk(K_SWITCH, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0); // RQ8
            8'h07: so = mk(K_SWITCH, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1); // RQ9
            8'h08: so = mk(K_SWITCH, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1); // RQ10
            8'h09: so = mk(K_SWITCH, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0); // RQ11
            8'h0A: so = mk(K_SWITCH, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0); // RQ12
            8'h0B: so = mk(K_SWITCH, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1); // RQ9
            8'h0C: so = mk(K_SWITCH, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1); // RQ10
            8'h0D: so = mk(K_SWITCH, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0); // RQ11
            8'h0E: so = mk(K_SWITCH, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0); // RQ12
            8'h18: so = mk(K_SWITCH, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1); // RQ14
            8'h1A: so = mk(K_SWITCH, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0); // RQ14
            8'h1C: so = mk(K_SWITCH, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1); // RQ14
            8'h1E: so = mk(K_SWITCH, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0); // RQ14
            8'h21: so = mk(K_INDEX, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0); // RQ15
            8'h22: so = mk(K_INDEX, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0); // RQ15
            default: so = '0;
        endcase
        case (m)
            8'hFC: r = mk(K_TORQ, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0); // RQ5
            8'hFD: r = mk(K_TORQ, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0); // RQ5
            8'h14: r = mk(K_SWITCH, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0); // RQ13
            8'h16: r = mk(K_SWITCH, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0); // RQ13
            8'h23: r = mk(K_HERE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0); // RQ16
            8'h25: r = mk(K_OFFSET, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0); // RQ16
            default: r = sv ? so : '0; // RQ7
        endcase
        dec = r;
    endfunction

    assign desc = dec(method, servo);
endmodule

// File: hw/hsc_top.sv
// homing sequence controller: apb registers, method decode and search sequencer
// assumes home switch, limits, index and stall arrive asynchronously from pins;
// actual position comes from logic on the same clock
`timescale 1ns/1ps
module hsc_top
(
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic HOME_SENSOR_INPUT,
    input wire logic LIMIT_POS,
    input wire logic LIMIT_NEG,
    input wire logic INDEX_PULSE,
    input wire logic TORQUE_STALL,
    input wire logic [31:0] POS_ACTUAL,
    output logic MOVE_EN,
    output logic MOVE_DIR_POS,
    output logic [15:0] TORQUE_LIMIT,
    output logic POS_LOAD,
    output logic [31:0] POS_LOAD_VAL,
    output logic [7:0] MODE_ACTIVE
);
    import hsc_pkg::*;
    hsc_regs_if rif();
    hsc_desc_t desc;
    hsc_desc_t run_reg;
    hsc_state_t state_reg;
    logic [3:0] sy1_reg, sy2_reg;
    logic home_d_reg, idx_d_reg;
    logic home_s, lpos_s, lneg_s, idx_s, stall_s;
    logic home_hit, idx_hit, lim_hit;
    logic busy, start_ok, finish_ok, finish_bad;
    logic dir_reg, en_reg, revd_reg;
    logic done_reg, err_reg, ref_reg, refused_reg;
    logic load_reg;
    logic [31:0] load_val_reg, ref_pos_reg;
    logic [7:0] mode_reg;
    logic [15:0] torq_reg;

    hsc_apb_regs u_regs
    (
        .clk(REF_CLK),
        .srst(SRST),
        .psel(PSEL),
        .penable(PENABLE),
        .pwrite(PWRITE),
        .paddr(PADDR),
        .pwdata(PWDATA),
        .prdata(PRDATA),
        .pready(PREADY),
        .pslverr(PSLVERR),
        .rif(rif.regs)
    );

    hsc_method_dec u_dec
    (
        .method(rif.method),
        .servo(rif.servo),
        .desc(desc)
    );

    // two-stage synchronisers; only the second stage feeds logic
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            sy1_reg <= 4'h0;
            sy2_reg <= 4'h0;
            home_d_reg <= 1'b0;
            idx_d_reg <= 1'b0;
        end
        else
        begin
            sy1_reg <= {HOME_SENSOR_INPUT, LIMIT_POS, LIMIT_NEG, INDEX_PULSE}; // RQ1
            sy2_reg <= sy1_reg;
            home_d_reg <= sy2_reg[3];
            idx_d_reg <= sy2_reg[0];
        end
    end

    // stall is a level from the current loop, one more sync pair
    logic [1:0] st_sy_reg;
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            st_sy_reg <= 2'b00;
        else
            st_sy_reg <= {st_sy_reg[0], TORQUE_STALL};
    end

    assign home_s = sy2_reg[3];
    assign lpos_s = sy2_reg[2];
    assign lneg_s = sy2_reg[1];
    assign idx_s = sy2_reg[0];
    assign stall_s = st_sy_reg[1];
    assign home_hit = home_s && !home_d_reg;
    assign idx_hit = idx_s && !idx_d_reg;
    // limits are ignored entirely unless software enabled them
    assign lim_hit = rif.lim_en && (dir_reg ? lpos_s : lneg_s); // RQ2

    assign busy = state_reg != S_IDLE;
    assign start_ok = rif.start_p && !busy && mode_reg == MODE_HOMING;

    // run finishes well on the stopping event of its pattern
    always_comb
    begin
        finish_ok = 1'b0;
        finish_bad = 1'b0;
        case (state_reg)
            S_IDLE:
            begin
                finish_bad = start_ok && !desc.valid; // RQ7
                finish_ok = start_ok && desc.valid
                    && (desc.kind == K_HERE || desc.kind == K_OFFSET
                    || (desc.chk_home && home_s && !desc.use_idx)); // RQ16 RQ14
            end
            S_SRCH:
            begin
                finish_ok = home_hit && !run_reg.use_idx; // RQ13 RQ14
                finish_bad = !home_hit && lim_hit && (!run_reg.rev_lim || revd_reg);
            end
            S_TORQ: finish_ok = stall_s && !run_reg.use_idx; // RQ5
            S_INDX:
            begin
                finish_ok = idx_hit; // RQ15
                finish_bad = lim_hit && !idx_hit;
            end
            default:
            begin
                finish_ok = 1'b0;
                finish_bad = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            state_reg <= S_IDLE;
            run_reg <= '0;
            dir_reg <= 1'b1;
            revd_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                S_IDLE:
                begin
                    if (start_ok && desc.valid)
                    begin
                        run_reg <= desc;
                        dir_reg <= desc.dir_pos;
                        revd_reg <= 1'b0;
                        if (desc.kind == K_TORQ)
                            state_reg <= S_TORQ;
                        else if (desc.kind == K_INDEX)
                            state_reg <= S_INDX;
                        else if (desc.kind == K_SWITCH)
                        begin
                            // already on the switch: treat as found at once
                            if (desc.chk_home && home_s) // RQ9 RQ10 RQ14
                            begin
                                state_reg <= desc.use_idx ? S_INDX : S_IDLE;
                                dir_reg <= desc.dir_pos ^ desc.flip_home;
                            end
                            else
                                state_reg <= S_SRCH;
                        end
                    end
                end
                S_SRCH:
                begin
                    if (home_hit)
                    begin
                        state_reg <= run_reg.use_idx ? S_INDX : S_IDLE; // RQ8 RQ11
                        dir_reg <= dir_reg ^ run_reg.flip_home; // RQ9 RQ12
                    end
                    else if (finish_bad)
                        state_reg <= S_IDLE;
                    else if (lim_hit && run_reg.rev_lim)
                    begin
                        dir_reg <= !dir_reg; // RQ11 RQ12
                        revd_reg <= 1'b1;
                    end
                end
                S_TORQ:
                begin
                    if (stall_s)
                        state_reg <= run_reg.use_idx ? S_INDX : S_IDLE; // RQ6
                end
                S_INDX:
                begin
                    if (idx_hit || lim_hit)
                        state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // motion request follows the state; stopped the edge the run ends
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            en_reg <= 1'b0;
        else if (finish_ok || finish_bad)
            en_reg <= 1'b0;
        else
            en_reg <= busy || (start_ok && desc.valid
                && desc.kind != K_HERE && desc.kind != K_OFFSET);
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            torq_reg <= TORQ_RST;
        else
            torq_reg <= (mode_reg == MODE_HOMING) ? rif.htorq : rif.ptorq; // RQ3
    end

    // sticky flags: a set in the same cycle as a clear wins
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            ref_reg <= 1'b0;
            refused_reg <= 1'b0;
        end
        else
        begin
            if (finish_ok || finish_bad)
                done_reg <= 1'b1; // RQ21
            else if (rif.clr_p || start_ok)
                done_reg <= 1'b0;
            if (finish_bad || (rif.start_p && !start_ok))
                err_reg <= 1'b1; // RQ7
            else if (rif.clr_p || start_ok)
                err_reg <= 1'b0;
            if (finish_ok)
                ref_reg <= 1'b1; // RQ21
            else if (start_ok)
                ref_reg <= 1'b0;
            if (rif.mode_wr_p && busy)
                refused_reg <= 1'b1; // RQ20
            else if (rif.clr_p)
                refused_reg <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
            mode_reg <= MODE_RST;
        else if (rif.mode_wr_p && !busy)
            mode_reg <= rif.mode_wdata; // RQ20
    end

    // home reference: offset for every pattern but 35, present position kept for 35
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            load_reg <= 1'b0;
            load_val_reg <= ZERO_POS;
            ref_pos_reg <= ZERO_POS;
        end
        else
        begin
            load_reg <= finish_ok;
            if (finish_ok)
            begin
                if (state_reg == S_IDLE && desc.kind == K_HERE)
                begin
                    load_val_reg <= POS_ACTUAL; // RQ16
                    ref_pos_reg <= POS_ACTUAL;
                end
                else
                begin
                    load_val_reg <= rif.offset; // RQ16
                    ref_pos_reg <= rif.offset;
                end
            end
        end
    end

    assign rif.status = {refused_reg, ref_reg, err_reg, done_reg, busy};
    assign rif.mode_act = mode_reg;
    assign rif.ref_pos = ref_pos_reg;
    assign MOVE_EN = en_reg;
    assign MOVE_DIR_POS = dir_reg;
    assign TORQUE_LIMIT = torq_reg;
    assign POS_LOAD = load_reg;
    assign POS_LOAD_VAL = load_val_reg;
    assign MODE_ACTIVE = mode_reg;

    chk_torque_limit: assert property (@(posedge REF_CLK) disable iff (SRST) // RQ3
        busy |=> TORQUE_LIMIT == $past(rif.htorq))
        else $error("homing torque not applied");
    chk_reject_code: assert property (@(posedge REF_CLK) disable iff (SRST) // RQ7
        start_ok && !desc.valid |=> err_reg && done_reg && !MOVE_EN && !busy)
        else $error("unsupported method was not rejected");
    chk_mode_hold: assert property (@(posedge REF_CLK) disable iff (SRST) // RQ20
        rif.mode_wr_p && busy |=> MODE_ACTIVE == $past(MODE_ACTIVE) && refused_reg)
        else $error("mode changed during homing");
    chk_ref_success: assert property (@(posedge REF_CLK) disable iff (SRST) // RQ21
        $rose(ref_reg) |-> done_reg && !err_reg && POS_LOAD)
        else $error("reference set without a good finish");
    chk_torq_dir: assert property (@(posedge REF_CLK) disable iff (SRST) // RQ5
        state_reg == S_TORQ |-> MOVE_DIR_POS == run_reg.dir_pos
        && TORQUE_LIMIT == $past(rif.htorq))
        else $error("torque homing direction wrong");
    chk_torq_index: assert property (@(posedge REF_CLK) disable iff (SRST) // RQ6
        state_reg == S_TORQ && stall_s && run_reg.use_idx |=> state_reg == S_INDX && MOVE_EN)
        else $error("torque homing did not go on to index");
    chk_index_stop: assert property (@(posedge REF_CLK) disable iff (SRST) // RQ15
        state_reg == S_INDX && idx_hit |=> !MOVE_EN && !busy && ref_reg ##1 !POS_LOAD)
        else $error("index did not end the run");
    chk_limit_gate: assert property (@(posedge REF_CLK) disable iff (SRST) // RQ2
        state_reg == S_SRCH && !rif.lim_en && !home_hit |=> $stable(MOVE_DIR_POS))
        else $error("disabled limit switch reversed motion");
    chk_switch_stop: assert property (@(posedge REF_CLK) disable iff (SRST) // RQ13
        state_reg == S_SRCH && home_hit && !run_reg.use_idx |=> !busy && ref_reg && POS_LOAD)
        else $error("home switch did not end the run");
    chk_offset_load: assert property (@(posedge REF_CLK) disable iff (SRST) // RQ16
        start_ok && desc.kind == K_OFFSET && desc.valid
        |=> POS_LOAD && POS_LOAD_VAL == $past(rif.offset) && !MOVE_EN)
        else $error("offset method did not load the offset");
endmodule

// File: tb/hsc_env.sv
// motion model: home switch, limits, stall and index seen by the drive
// assumes move_en is the drive's command, on the bench clock
`timescale 1ns/1ps
module hsc_env
(
    input wire logic clk,
    input wire logic move_en,
    input wire logic lim_on,
    input wire logic dir,
    output logic home,
    output logic idx,
    output logic stall,
    output logic lim_p,
    output logic lim_n
);
    int cnt = 0;
    always @(posedge clk)
    begin
        cnt <= move_en ? cnt + 1 : 0;
    end
    // switch reaches only the dedicated home input
    assign home = cnt >= 8;
    assign stall = cnt >= 8;
    // index held 2 clocks so the synchroniser sees it
    assign idx = cnt >= 12 && cnt < 14;
    // one-cycle limit early in a move, only on the side the drive heads to
    assign lim_p = lim_on && dir && cnt == 2;
    assign lim_n = lim_on && !dir && cnt == 2;
endmodule

// File: tb/hsc_top_tb.sv
// bench for hsc_top: apb master, method sweep, mode refusal
// assumes hsc_env drives the switch and limit inputs
`timescale 1ns/1ps
module hsc_top_tb;
    import hsc_pkg::*;
    logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, se, me, dp, pl, home, idx, st;
    logic [7:0] pa = 0, ma;
    logic [31:0] pw = 0, pr, r, pos, off, lv;
    logic [15:0] ht, tl;
    logic pready;
    logic lon = 0, lp, ln;
    int bad_count = 0, tests_run = 0, cyc = 0;
    int nload = 0;
    int ok[$] = '{-4, -3, -2, -1, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 20, 22, 24, 26, 28,
        30, 33, 34, 35, 37};
    int codes[$] = '{-5, -4, -3, -2, -1, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15,
        16, 17, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27, 28, 29, 30, 31, 32, 33, 34, 35, 36, 37, 38};
    hsc_top dut_u (.REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(pa), .PWDATA(pw), .PRDATA(pr), .PREADY(pready), .PSLVERR(se),
        .HOME_SENSOR_INPUT(home), .LIMIT_POS(lp), .LIMIT_NEG(ln), .INDEX_PULSE(idx),
        .TORQUE_STALL(st), .POS_ACTUAL(pos), .MOVE_EN(me), .MOVE_DIR_POS(dp),
        .TORQUE_LIMIT(tl), .POS_LOAD(pl), .POS_LOAD_VAL(lv), .MODE_ACTIVE(ma));
    hsc_env env_u (.clk(clk), .move_en(me), .lim_on(lon), .dir(dp), .home(home), .idx(idx),
        .stall(st), .lim_p(lp), .lim_n(ln));
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            final_report;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // motion must use the homing torque
    always @(posedge clk)
    begin
        if (me === 1'b1)
            chk(tl, ht);
        if (pl === 1'b1)
            nload++;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pw <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        r = pr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic wait_done;
        repeat (100)
        begin
            apb(0, OFF_STATUS, 0);
            if (r[ST_DONE] === 1'b1)
                break;
        end
    endtask
    task automatic run(input int c, input logic [31:0] ctl, input logic [31:0] e);
        apb(1, OFF_METHOD, 32'(c));
        apb(1, OFF_CTRL, ctl);
        wait_done;
        chk(r, e);
        chk({31'h0, me}, 0);
    endtask
    initial
    begin
        void'($urandom(32'h41fbd978));
        pos = $urandom;
        ht = 16'($urandom);
        off = $urandom;
        repeat (6) @(posedge clk);
        srst <= 0;
        apb(0, OFF_MODE, 0);
        chk(r, 0);
        apb(0, 8'h20, 0);
        chk({31'h0, se}, 1);
        $display("reset and unmapped done");
        apb(1, OFF_HTORQ, {16'h0, ht});
        apb(1, OFF_OFFSET, off);
        apb(1, OFF_MODE, 6);
        foreach (codes[i])
        begin
            run(codes[i], 32'h0000_0007,
                (codes[i] inside {ok}) ? 32'h0000_000A : 32'h0000_0006);
            apb(0, OFF_REFPOS, 0);
            if (codes[i] inside {ok})
            begin
                chk(r, codes[i] == 35 ? pos : off);
                chk(lv, codes[i] == 35 ? pos : off);
            end
        end
        chk(nload, ok.size());
        run(-2, 32'h0000_0003, 32'h0000_0006);
        $display("method sweep done");
        lon <= 1;
        run(26, 32'h0000_0007, 32'h0000_000A);
        chk({31'h0, dp}, 0);
        run(30, 32'h0000_0007, 32'h0000_000A);
        chk({31'h0, dp}, 1);
        run(20, 32'h0000_0007, 32'h0000_0006);
        run(20, 32'h0000_0005, 32'h0000_000A);
        lon <= 0;
        $display("limit switches done");
        apb(1, OFF_METHOD, 20);
        apb(1, OFF_CTRL, 32'h0000_0007);
        apb(1, OFF_MODE, 0);
        wait_done;
        chk(r, 32'h0000_001A);
        apb(0, OFF_MODE, 0);
        chk(r, 6);
        chk(ma, 6);
        apb(1, OFF_CTRL, 32'h0000_000E);
        apb(1, OFF_MODE, 0);
        apb(0, OFF_MODE, 0);
        chk(r, 0);
        chk(ma, 0);
        $display("mode refusal done");
        final_report;
    end
endmodule
